/* File: include/smv_pkg.sv */
// Constants, types and helper functions shared by the shaft monitor vote logic
// ---------------------------------------------------------------------------
// Notes on behaviour
// - Radial peak-to-peak scale 125 um, optional 250
// - Peak-to-peak taken straight from transducer input
// - Radial fault 125 um inside range, floor 250
// - Radial X-Y pair, selectable 1oo2/2oo2, 2oo2 default
// - Radial 2oo2 needs both for delay; fault alarms
// - Contact plus enable multiplies radial setpoints by 2/3
// - Multiplier indicator; amplitude outputs left untouched
// - No runout or noise subtraction anywhere
// - Axial full scale -1 mm to +1 mm
// - Axial fault at range end, floor 250 um
// - Axial pair, own zero/gain, shared setpoints
// - Axial 1oo2/2oo2 select, at-or-beyond counts
// - Axial 2oo2 needs joint uninterrupted delay
// - Single axial failure: fault plus alert only
// - Axial 2oo2 trips on three listed cases
// - Axial display direction per channel, rising default
// - Rod drop display +-9.99 mm, 1 um steps
// - Rod fault at range end, floor 1 mm
// - Rod danger when any sensor reaches setpoint
// - Rod scale 7.87 or 3.94 mV/um, +-50% trim
// - Rod triggered or stroke-average display modes
// - Rod baseline reset command zeroes wear reading
// - Danger persistence 1 to 3 s, 1 s default
// ---------------------------------------------------------------------------
package smv_pkg;

  localparam int unsigned CLK_HZ         = 125_000_000;
  localparam int unsigned PERSIST_UNIT_S = 1;
  localparam int unsigned SEC_CYC        = PERSIST_UNIT_S * CLK_HZ;
  localparam logic [1:0]  DLY_SEL_2S     = 2'h2;
  localparam logic [1:0]  DLY_SEL_3S     = 2'h3;

  localparam logic [15:0] RAD_FS_STD_UM   = 16'h007d;
  localparam logic [15:0] RAD_FS_WIDE_UM  = 16'h00fa;
  localparam logic [15:0] RAD_MARGIN_UM   = 16'h007d;
  localparam logic [15:0] RAD_FLOOR_UM    = 16'h00fa;
  localparam logic [15:0] AX_FLOOR_UM     = 16'h00fa;
  localparam logic [15:0] ROD_FLOOR_UM    = 16'h03e8;
  localparam logic [15:0] NO_MARGIN_UM    = 16'h0000;
  localparam logic signed [15:0] AX_FS_UM  = 16'sh03e8;
  localparam logic signed [15:0] ROD_FS_UM = 16'sh2706;

  localparam logic [1:0]  MULT_STD = 2'h3;
  localparam logic [1:0]  MULT_ALT = 2'h2;

  // Reciprocal sensitivity in Q16: 65536/7.87 and 65536/3.94
  localparam logic [15:0] ROD_K_STD  = 16'h2087;
  localparam logic [15:0] ROD_K_LOW  = 16'h40fa;
  localparam logic [8:0]  TRIM_UNITY = 9'h100;
  localparam logic [8:0]  TRIM_MIN   = 9'h080;
  localparam logic [8:0]  TRIM_MAX   = 9'h180;

  typedef enum logic [0:0] {
    ROD_WAIT   = 1'b0,
    ROD_STROKE = 1'b1
  } smv_rod_st_t;

  // Fault when gap sits at or outside the usable window
  function automatic logic smv_fault(input logic [15:0] gap, input logic [15:0] lo,
                                     input logic [15:0] hi, input logic [15:0] margin,
                                     input logic [15:0] floor_um);
    logic [16:0] lo_t;
    logic [16:0] hi_t;
    lo_t = {1'b0, lo} + {1'b0, margin};
    if (lo_t < {1'b0, floor_um}) begin
      lo_t = {1'b0, floor_um};
    end
    hi_t = (hi > margin) ? {1'b0, hi - margin} : 17'h00000;
    return ({1'b0, gap} <= lo_t) || ({1'b0, gap} >= hi_t);
  endfunction : smv_fault

  function automatic logic signed [15:0] smv_clamp(input logic signed [27:0] v,
                                                   input logic signed [15:0] lim);
    if (v > 28'(lim)) begin
      return lim;
    end else if (v < -28'(lim)) begin
      return -lim;
    end
    return v[15:0];
  endfunction : smv_clamp

  function automatic logic [15:0] smv_abs(input logic signed [15:0] v);
    return v[15] ? 16'(-v) : v;
  endfunction : smv_abs

  // Counter restarts whenever the violation drops, so persistence is uninterrupted
  function automatic logic [31:0] smv_persist(input logic [31:0] cnt, input logic cond,
                                              input logic [31:0] lim);
    if (!cond) begin
      return 32'h0000_0000;
    end else if (cnt < lim) begin
      return cnt + 32'h0000_0001;
    end
    return cnt;
  endfunction : smv_persist

endpackage : smv_pkg

/* File: include/smv_div_if.sv */
// Request and answer signals between the monitor and its stroke-average divider
`timescale 1ns/1ps
interface smv_div_if #(
  parameter int NUM_W = 40,
  parameter int DEN_W = 24
);
  logic             start;
  logic [NUM_W-1:0] num;
  logic [DEN_W-1:0] den;
  logic             busy;
  logic             done;
  logic [15:0]      quot;

  modport req (output start, output num, output den, input busy, input done, input quot);
  modport div (input start, input num, input den, output busy, output done, output quot);
endinterface : smv_div_if

/* File: core/smv_avg_div.sv */
// Serial restoring divider used to average gap over one stroke
`timescale 1ns/1ps
module smv_avg_div #(
  parameter int NUM_W = 40,
  parameter int DEN_W = 24
) (
  input  wire logic ref_clk_i,
  input  wire logic rst_b_i,
  smv_div_if.div    dv
);
  import smv_pkg::*;

  localparam int CW = $clog2(NUM_W + 1);

  if (NUM_W < 16 || DEN_W < 1 || DEN_W > NUM_W) begin : g_chk
    $error("smv_avg_div: unsupported widths");
  end

  typedef struct packed {
    logic             busy;
    logic             done;
    logic [CW-1:0]    cnt;
    logic [DEN_W:0]   rem;
    logic [NUM_W-1:0] quo;
    logic [DEN_W-1:0] den;
    logic [15:0]      quot;
  } smv_div_st_t;

  smv_div_st_t st_ff;
  smv_div_st_t nxt_st;
  logic [DEN_W:0] rem_sh;

  always_comb begin
    nxt_st      = st_ff;
    nxt_st.done = 1'b0;
    rem_sh      = {st_ff.rem[DEN_W-1:0], st_ff.quo[NUM_W-1]};
    if (!st_ff.busy) begin
      if (dv.start) begin
        nxt_st.busy = 1'b1;
        nxt_st.cnt  = CW'(NUM_W);
        nxt_st.rem  = '0;
        nxt_st.quo  = dv.num;
        nxt_st.den  = dv.den;
      end
    end else begin
      if (rem_sh >= {1'b0, st_ff.den}) begin
        nxt_st.rem = rem_sh - {1'b0, st_ff.den};
        nxt_st.quo = {st_ff.quo[NUM_W-2:0], 1'b1};
      end else begin
        nxt_st.rem = rem_sh;
        nxt_st.quo = {st_ff.quo[NUM_W-2:0], 1'b0};
      end
      nxt_st.cnt = st_ff.cnt - CW'(1);
      if (st_ff.cnt == CW'(1)) begin
        nxt_st.busy = 1'b0;
        nxt_st.done = 1'b1;
        // Mean never exceeds a 16-bit sample
        nxt_st.quot = nxt_st.quo[15:0];
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign dv.busy = st_ff.busy;
  assign dv.done = st_ff.done;
  assign dv.quot = st_ff.quot;

endmodule : smv_avg_div

/* File: core/smv_vote_top.sv */
// Radial, axial and rod drop channel evaluation with shutdown voting
`timescale 1ns/1ps
module smv_vote_top #(
  parameter int unsigned SEC_CYC_P = smv_pkg::SEC_CYC,
  parameter int          AVG_NUM_W = 40,
  parameter int          AVG_DEN_W = 24
) (
  input  wire logic                ref_clk_i,
  input  wire logic                rst_b_i,
  // Configuration
  input  wire logic                rad_range_wide_i,
  input  wire logic                rad_vote_single_i,
  input  wire logic                mult_en_i,
  input  wire logic                mult_two_i,
  input  wire logic                mult_contact_i,
  input  wire logic [1:0]          delay_sel_i,
  input  wire logic                ax_vote_single_i,
  input  wire logic [1:0]          ax_dir_down_i,
  input  wire logic                rod_sf_low_i,
  input  wire logic [8:0]          rod_trim_i,
  input  wire logic                rod_avg_mode_i,
  input  wire logic [23:0]         rod_trig_dly_i,
  input  wire logic                phase_ref_i,
  input  wire logic                rod_base_rst_i,
  // Setpoints and linear ranges
  input  wire logic [15:0]         rad_alert_sp_i,
  input  wire logic [15:0]         rad_danger_sp_i,
  input  wire logic [15:0]         ax_alert_sp_i,
  input  wire logic [15:0]         ax_danger_sp_i,
  input  wire logic [15:0]         rod_alert_sp_i,
  input  wire logic [15:0]         rod_danger_sp_i,
  input  wire logic [15:0]         rad_lin_lo_i,
  input  wire logic [15:0]         rad_lin_hi_i,
  input  wire logic [15:0]         ax_lin_lo_i,
  input  wire logic [15:0]         ax_lin_hi_i,
  input  wire logic [15:0]         rod_lin_lo_i,
  input  wire logic [15:0]         rod_lin_hi_i,
  // Measurements
  input  wire logic [15:0]         rad_pp_x_i,
  input  wire logic [15:0]         rad_pp_y_i,
  input  wire logic [15:0]         rad_gap_x_i,
  input  wire logic [15:0]         rad_gap_y_i,
  input  wire logic signed [15:0]  ax_raw_a_i,
  input  wire logic signed [15:0]  ax_raw_b_i,
  input  wire logic [15:0]         ax_gap_a_i,
  input  wire logic [15:0]         ax_gap_b_i,
  input  wire logic signed [15:0]  ax_zero_a_i,
  input  wire logic signed [15:0]  ax_zero_b_i,
  input  wire logic [9:0]          ax_gain_a_i,
  input  wire logic [9:0]          ax_gain_b_i,
  input  wire logic [15:0]         rod_gap_mv_i,
  // Relays and indications
  output logic                     rad_alert_o,
  output logic                     rad_danger_o,
  output logic                     ax_alert_o,
  output logic                     ax_danger_o,
  output logic                     rod_alert_o,
  output logic                     rod_danger_o,
  output logic                     circuit_fault_o,
  output logic [4:0]               fault_o,
  output logic                     mult_active_o,
  output logic                     rad_over_o,
  output logic [15:0]              rad_pp_x_o,
  output logic [15:0]              rad_pp_y_o,
  output logic signed [15:0]       ax_pos_a_o,
  output logic signed [15:0]       ax_pos_b_o,
  output logic signed [15:0]       rod_drop_o
);
  import smv_pkg::*;

  if (SEC_CYC_P < 1 || 64'(SEC_CYC_P) * 64'd3 > 64'h0000_0000_ffff_ffff) begin : g_chk_sec
    $error("smv_vote_top: SEC_CYC_P out of range");
  end
  if (AVG_DEN_W < 8 || AVG_NUM_W < AVG_DEN_W + 16) begin : g_chk_avg
    $error("smv_vote_top: average widths too small");
  end

  // -------------------------------------------------------------------------
  // State
  // -------------------------------------------------------------------------
  typedef struct packed {
    logic [1:0]            mc_s;
    logic [1:0]            ph_s;
    logic                  ph_d;
    logic [1:0]            br_s;
    logic                  br_d;
    logic [31:0]           rad_cnt;
    logic [31:0]           ax_cnt;
    logic [31:0]           rod_cnt;
    smv_rod_st_t           rod_st;
    logic [AVG_NUM_W-1:0]  sum;
    logic [AVG_DEN_W-1:0]  nsamp;
    logic [23:0]           trig_cnt;
    logic                  trig_arm;
    logic [15:0]           trig_val;
    logic [15:0]           avg_val;
    logic [15:0]           base;
    logic                  div_go;
    logic [AVG_NUM_W-1:0]  div_num;
    logic [AVG_DEN_W-1:0]  div_den;
    logic                  rad_alert;
    logic                  rad_danger;
    logic                  ax_alert;
    logic                  ax_danger;
    logic                  rod_alert;
    logic                  rod_danger;
    logic [4:0]            fault;
    logic                  mult_on;
    logic                  rad_over;
    logic [15:0]           pp_x;
    logic [15:0]           pp_y;
    logic signed [15:0]    pos_a;
    logic signed [15:0]    pos_b;
    logic signed [15:0]    drop;
  } smv_top_st_t;

  smv_top_st_t st_ff;
  smv_top_st_t nxt_st;

  smv_div_if #(.NUM_W(AVG_NUM_W), .DEN_W(AVG_DEN_W)) div_bus ();

  smv_avg_div #(.NUM_W(AVG_NUM_W), .DEN_W(AVG_DEN_W)) u_avg_div (
    .ref_clk_i (ref_clk_i),
    .rst_b_i   (rst_b_i),
    .dv        (div_bus.div)
  );

  assign div_bus.start = st_ff.div_go;
  assign div_bus.num   = st_ff.div_num;
  assign div_bus.den   = st_ff.div_den;

  // -------------------------------------------------------------------------
  // Combinational evaluation
  // -------------------------------------------------------------------------
  logic [31:0]        dly_lim;
  logic [1:0]         mult;
  logic [17:0]        rad_alert_eff;
  logic [17:0]        rad_danger_eff;
  logic [15:0]        rad_fs;
  logic               fx;
  logic               fy;
  logic               dx;
  logic               dy;
  logic               rad_cond;
  logic signed [16:0] dev_a;
  logic signed [16:0] dev_b;
  logic signed [27:0] scl_a;
  logic signed [27:0] scl_b;
  logic signed [15:0] pa;
  logic signed [15:0] pb;
  logic               fa;
  logic               fb;
  logic               va;
  logic               vb;
  logic               ax_cond;
  logic [8:0]         trim;
  logic [24:0]        k_eff;
  logic [40:0]        rod_prod;
  logic [15:0]        rod_um;
  logic               frod;
  logic               ph_edge;
  logic               br_edge;
  logic [15:0]        rod_val;
  logic signed [15:0] rod_drop;
  logic               rod_cond;

  always_comb begin
    nxt_st = st_ff;

    // Contact, phase reference and baseline reset inputs pass two flops before use
    nxt_st.mc_s = {st_ff.mc_s[0], mult_contact_i};
    nxt_st.ph_s = {st_ff.ph_s[0], phase_ref_i};
    nxt_st.br_s = {st_ff.br_s[0], rod_base_rst_i};
    nxt_st.ph_d = st_ff.ph_s[1];
    nxt_st.br_d = st_ff.br_s[1];
    ph_edge     = st_ff.ph_s[1] & ~st_ff.ph_d;
    br_edge     = st_ff.br_s[1] & ~st_ff.br_d;

    if (delay_sel_i == DLY_SEL_3S) begin
      dly_lim = 32'(SEC_CYC_P) * 32'd3;
    end else if (delay_sel_i == DLY_SEL_2S) begin
      dly_lim = 32'(SEC_CYC_P) * 32'd2;
    end else begin
      dly_lim = 32'(SEC_CYC_P);
    end

    // Radial pair
    nxt_st.mult_on = mult_en_i & st_ff.mc_s[1];
    mult           = mult_two_i ? MULT_ALT : MULT_STD;
    if (st_ff.mult_on) begin
      rad_alert_eff  = 18'(rad_alert_sp_i) * 18'(mult);
      rad_danger_eff = 18'(rad_danger_sp_i) * 18'(mult);
    end else begin
      rad_alert_eff  = 18'(rad_alert_sp_i);
      rad_danger_eff = 18'(rad_danger_sp_i);
    end
    rad_fs = rad_range_wide_i ? RAD_FS_WIDE_UM : RAD_FS_STD_UM;
    fx = smv_fault(rad_gap_x_i, rad_lin_lo_i, rad_lin_hi_i, RAD_MARGIN_UM, RAD_FLOOR_UM);
    fy = smv_fault(rad_gap_y_i, rad_lin_lo_i, rad_lin_hi_i, RAD_MARGIN_UM, RAD_FLOOR_UM);
    // Peak-to-peak used as delivered; nothing is subtracted
    dx = !fx && (18'(rad_pp_x_i) >= rad_danger_eff);
    dy = !fy && (18'(rad_pp_y_i) >= rad_danger_eff);
    // A failed channel never votes, so one failure only raises the fault
    rad_cond = rad_vote_single_i ? (dx | dy) : (dx & dy);
    nxt_st.rad_cnt    = smv_persist(st_ff.rad_cnt, rad_cond, dly_lim);
    nxt_st.rad_danger = rad_cond && (nxt_st.rad_cnt >= dly_lim);
    nxt_st.rad_alert  = (!fx && (18'(rad_pp_x_i) >= rad_alert_eff)) ||
                        (!fy && (18'(rad_pp_y_i) >= rad_alert_eff));
    nxt_st.rad_over   = (rad_pp_x_i > rad_fs) || (rad_pp_y_i > rad_fs);
    nxt_st.pp_x       = rad_pp_x_i;
    nxt_st.pp_y       = rad_pp_y_i;

    // Axial pair, gain in Q8
    dev_a = 17'(ax_raw_a_i) - 17'(ax_zero_a_i);
    dev_b = 17'(ax_raw_b_i) - 17'(ax_zero_b_i);
    scl_a = (28'(dev_a) * $signed({18'h00000, ax_gain_a_i})) >>> 8;
    scl_b = (28'(dev_b) * $signed({18'h00000, ax_gain_b_i})) >>> 8;
    if (ax_dir_down_i[0]) begin
      scl_a = -scl_a;
    end
    if (ax_dir_down_i[1]) begin
      scl_b = -scl_b;
    end
    pa = smv_clamp(scl_a, AX_FS_UM);
    pb = smv_clamp(scl_b, AX_FS_UM);
    fa = smv_fault(ax_gap_a_i, ax_lin_lo_i, ax_lin_hi_i, NO_MARGIN_UM, AX_FLOOR_UM);
    fb = smv_fault(ax_gap_b_i, ax_lin_lo_i, ax_lin_hi_i, NO_MARGIN_UM, AX_FLOOR_UM);
    va = !fa && (smv_abs(pa) >= ax_danger_sp_i);
    vb = !fb && (smv_abs(pb) >= ax_danger_sp_i);
    if (ax_vote_single_i) begin
      ax_cond = va | vb | (fa & fb);
    end else begin
      ax_cond = (fa & fb) | (fa & vb) | (fb & va) | (va & vb);
    end
    nxt_st.ax_cnt    = smv_persist(st_ff.ax_cnt, ax_cond, dly_lim);
    nxt_st.ax_danger = ax_cond && (nxt_st.ax_cnt >= dly_lim);
    nxt_st.ax_alert  = fa || fb ||
                       (smv_abs(pa) >= ax_alert_sp_i) || (smv_abs(pb) >= ax_alert_sp_i);
    nxt_st.pos_a     = pa;
    nxt_st.pos_b     = pb;

    // Rod drop: gap volts to micrometres via trimmed reciprocal scale
    if (rod_trim_i < TRIM_MIN) begin
      trim = TRIM_MIN;
    end else if (rod_trim_i > TRIM_MAX) begin
      trim = TRIM_MAX;
    end else begin
      trim = rod_trim_i;
    end
    k_eff    = (25'(rod_sf_low_i ? ROD_K_LOW : ROD_K_STD) * 25'(trim)) >> 8;
    rod_prod = 41'(rod_gap_mv_i) * 41'(k_eff);
    rod_um   = (rod_prod[40:32] != 9'h000) ? 16'hffff : rod_prod[31:16];
    frod     = smv_fault(rod_um, rod_lin_lo_i, rod_lin_hi_i, NO_MARGIN_UM, ROD_FLOOR_UM);

    nxt_st.div_go = 1'b0;
    case (st_ff.rod_st)
      ROD_WAIT: begin
        if (ph_edge) begin
          nxt_st.rod_st   = ROD_STROKE;
          nxt_st.sum      = '0;
          nxt_st.nsamp    = '0;
          nxt_st.trig_cnt = rod_trig_dly_i;
          nxt_st.trig_arm = 1'b1;
        end
      end
      ROD_STROKE: begin
        if (ph_edge) begin
          // One stroke per phase reference mark; a busy divider skips a stroke
          if (st_ff.nsamp != '0 && !div_bus.busy && !st_ff.div_go) begin
            nxt_st.div_go  = 1'b1;
            nxt_st.div_num = st_ff.sum;
            nxt_st.div_den = st_ff.nsamp;
          end
          nxt_st.sum      = AVG_NUM_W'(rod_um);
          nxt_st.nsamp    = AVG_DEN_W'(1);
          nxt_st.trig_cnt = rod_trig_dly_i;
          nxt_st.trig_arm = 1'b1;
        end else if (st_ff.nsamp != '1) begin
          // Accumulation stops at a full count rather than wrapping
          nxt_st.sum   = st_ff.sum + AVG_NUM_W'(rod_um);
          nxt_st.nsamp = st_ff.nsamp + AVG_DEN_W'(1);
        end
        if (!ph_edge && st_ff.trig_arm) begin
          if (st_ff.trig_cnt == 24'h000000) begin
            nxt_st.trig_val = rod_um;
            nxt_st.trig_arm = 1'b0;
          end else begin
            nxt_st.trig_cnt = st_ff.trig_cnt - 24'h000001;
          end
        end
      end
      default: begin
        nxt_st.rod_st = ROD_WAIT;
      end
    endcase
    if (div_bus.done) begin
      nxt_st.avg_val = div_bus.quot;
    end

    rod_val = rod_avg_mode_i ? st_ff.avg_val : st_ff.trig_val;
    if (br_edge) begin
      nxt_st.base = rod_val;
    end
    rod_drop = smv_clamp(28'(rod_val) - 28'(st_ff.base), ROD_FS_UM);
    rod_cond = !frod && (smv_abs(rod_drop) >= rod_danger_sp_i);
    nxt_st.rod_cnt    = smv_persist(st_ff.rod_cnt, rod_cond, dly_lim);
    nxt_st.rod_danger = rod_cond && (nxt_st.rod_cnt >= dly_lim);
    nxt_st.rod_alert  = !frod && (smv_abs(rod_drop) >= rod_alert_sp_i);
    nxt_st.drop       = rod_drop;

    nxt_st.fault = {frod, fb, fa, fy, fx};
  end

  // -------------------------------------------------------------------------
  // Registers
  // -------------------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign rad_alert_o     = st_ff.rad_alert;
  assign rad_danger_o    = st_ff.rad_danger;
  assign ax_alert_o      = st_ff.ax_alert;
  assign ax_danger_o     = st_ff.ax_danger;
  assign rod_alert_o     = st_ff.rod_alert;
  assign rod_danger_o    = st_ff.rod_danger;
  assign fault_o         = st_ff.fault;
  assign circuit_fault_o = |st_ff.fault;
  assign mult_active_o   = st_ff.mult_on;
  assign rad_over_o      = st_ff.rad_over;
  assign rad_pp_x_o      = st_ff.pp_x;
  assign rad_pp_y_o      = st_ff.pp_y;
  assign ax_pos_a_o      = st_ff.pos_a;
  assign ax_pos_b_o      = st_ff.pos_b;
  assign rod_drop_o      = st_ff.drop;

endmodule : smv_vote_top

/* File: verif/smv_vote_chk.sv */
// Port assertions for the vote logic top
`timescale 1ns/1ps
module smv_vote_chk #(parameter int unsigned SEC_CYC_P = 20) (
  input wire logic               ref_clk_i,
  input wire logic               rst_b_i,
  input wire logic               rad_vote_single_i,
  input wire logic               mult_contact_i,
  input wire logic [15:0]        rad_pp_x_i,
  input wire logic [15:0]        ax_gap_a_i,
  input wire logic               rad_danger_o,
  input wire logic               ax_alert_o,
  input wire logic               rod_danger_o,
  input wire logic               circuit_fault_o,
  input wire logic [4:0]         fault_o,
  input wire logic               mult_active_o,
  input wire logic [15:0]        rad_pp_x_o,
  input wire logic signed [15:0] ax_pos_a_o
);
  import smv_pkg::*;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_b_i);
  fault_sum_a: assert property (circuit_fault_o == |fault_o)
    else $error("fault summary differs");
  pp_pass_a: assert property ($past(rst_b_i) |-> rad_pp_x_o == $past(rad_pp_x_i))
    else $error("amplitude output altered");
  rad_vote_a: assert property (rad_danger_o && !$past(rad_vote_single_i) |-> fault_o[1:0] == 2'h0)
    else $error("radial trip with a failed channel");
  rad_persist_a: assert property ($rose(rad_danger_o) |-> !$past(rad_danger_o, SEC_CYC_P))
    else $error("radial trip too soon");
  mult_ind_a: assert property ($rose(mult_active_o) |-> $past(mult_contact_i, 3))
    else $error("multiplier lamp without contact");
  ax_clamp_a: assert property (ax_pos_a_o <= AX_FS_UM && ax_pos_a_o >= -AX_FS_UM)
    else $error("axial position beyond scale");
  ax_fail_alert_a: assert property ($past(rst_b_i) && $past(ax_gap_a_i) <= AX_FLOOR_UM |-> ax_alert_o && fault_o[2])
    else $error("axial failure not alarmed");
  rod_fault_quiet_a: assert property (fault_o[4] |-> !rod_danger_o)
    else $error("rod trip on failed channel");
endmodule : smv_vote_chk

bind smv_vote_top smv_vote_chk #(.SEC_CYC_P(SEC_CYC_P)) i_chk (.*);

/* File: verif/smv_probe_mdl.sv */
// Behavioural rod probe and once-per-turn reference
`timescale 1ns/1ps
module smv_probe_mdl (
  input  wire logic        ref_clk_i,
  input  wire logic [15:0] mv_i,
  output logic             phase_ref_o,
  output logic [15:0]      mv_o
);
  int pos = 0;
  // 100-cycle stroke, short mark at its start
  always @(posedge ref_clk_i) begin
    pos <= (pos == 99) ? 0 : pos + 1;
    phase_ref_o <= (pos < 10);
    mv_o <= mv_i;
  end
endmodule : smv_probe_mdl

/* File: verif/test_smv_vote_top.sv */
// Self-checking bench for the vote logic top
`timescale 1ns/1ps
module test_smv_vote_top;
  import smv_pkg::*;
  localparam int SC = 20;
  logic ref_clk_i = 1'b0, rst_b_i = 1'b0;
  logic rad_range_wide_i, rad_vote_single_i, mult_en_i, mult_two_i, mult_contact_i, ax_vote_single_i;
  logic rod_sf_low_i, rod_avg_mode_i, phase_ref_i, rod_base_rst_i, rad_alert_o, rad_danger_o, ax_alert_o;
  logic ax_danger_o, rod_alert_o, rod_danger_o, circuit_fault_o, mult_active_o, rad_over_o;
  logic [1:0] delay_sel_i, ax_dir_down_i;
  logic [4:0] fault_o;
  logic [8:0] rod_trim_i;
  logic [9:0] ax_gain_a_i, ax_gain_b_i;
  logic [23:0] rod_trig_dly_i;
  logic [15:0] rad_alert_sp_i, rad_danger_sp_i, ax_alert_sp_i, ax_danger_sp_i, rod_alert_sp_i, rod_danger_sp_i;
  logic [15:0] rad_lin_lo_i, rad_lin_hi_i, ax_lin_lo_i, ax_lin_hi_i, rod_lin_lo_i, rod_lin_hi_i, mv, v;
  logic [15:0] rad_pp_x_i, rad_pp_y_i, rad_gap_x_i, rad_gap_y_i, ax_gap_a_i, ax_gap_b_i, rod_gap_mv_i;
  logic [15:0] rad_pp_x_o, rad_pp_y_o;
  logic signed [15:0] ax_raw_a_i, ax_raw_b_i, ax_zero_a_i, ax_zero_b_i, ax_pos_a_o, ax_pos_b_o, rod_drop_o;
  logic [5:0] ax_tab [6] = '{6'h04, 6'h07, 6'h10, 6'h13, 6'h19, 6'h25};
  int error_cnt = 0, check_count = 0, seed = 99, cyc = 0, n;

  smv_vote_top #(.SEC_CYC_P(SC)) i_dut (.*);
  smv_probe_mdl i_probe (.ref_clk_i(ref_clk_i), .mv_i(mv), .phase_ref_o(phase_ref_i), .mv_o(rod_gap_mv_i));

  always #4 ref_clk_i = ~ref_clk_i;
  always @(posedge ref_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      error_cnt++;
      complete_run();
    end
  end

  task automatic complete_run;
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : complete_run

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic tick(input int k);
    repeat (k) @(posedge ref_clk_i);
    #1;
  endtask : tick

  // Edges from the driving edge until the radial relay picks up
  task automatic meas(output int k);
    k = 0;
    do begin
      tick(1);
      k++;
    end while (!rad_danger_o && k < 300);
  endtask : meas

  function automatic int dly(input logic [1:0] s);
    return (s == DLY_SEL_3S) ? 3 * SC : (s == DLY_SEL_2S) ? 2 * SC : SC;
  endfunction : dly

  // ----
  // Main sequence
  // ----
  initial begin
    {rad_range_wide_i, rad_vote_single_i, mult_en_i, mult_two_i, mult_contact_i, ax_vote_single_i} = '0;
    {rod_sf_low_i, rod_avg_mode_i, rod_base_rst_i, delay_sel_i, ax_dir_down_i, ax_raw_a_i, ax_raw_b_i} = '0;
    {rad_pp_x_i, rad_pp_y_i, ax_zero_a_i, rad_lin_lo_i, ax_lin_lo_i, rod_lin_lo_i} = '0;
    {rad_gap_x_i, rad_gap_y_i, ax_gap_a_i, ax_gap_b_i} = {4{16'h07d0}};
    {rad_lin_hi_i, ax_lin_hi_i, rod_lin_hi_i, mv} = {{3{16'h4e20}}, 16'h3e80};
    {rad_alert_sp_i, rad_danger_sp_i, ax_alert_sp_i} = {16'h0046, 16'h0064, 16'h012c};
    {ax_danger_sp_i, rod_alert_sp_i, rod_danger_sp_i} = {16'h01f4, 16'h012c, 16'h0190};
    {rod_trim_i, rod_trig_dly_i, ax_gain_a_i, ax_gain_b_i, ax_zero_b_i} = {TRIM_UNITY, 24'h5, 20'h40200, 16'sh64};
    repeat (16) @(posedge ref_clk_i);
    rst_b_i <= 1'b1;
    tick(3);
    chk({rad_danger_o, ax_danger_o, circuit_fault_o, mult_active_o}, 0);
    for (int i = 0; i < 16; i++) begin
      @(posedge ref_clk_i);
      v = 16'($random(seed)) & 16'h00ff;
      {rad_pp_x_i, rad_pp_y_i, mult_contact_i, mult_en_i} <= {v, v ^ 16'h00ff, v[0], 1'b1};
      tick(1);
      chk({rad_pp_x_o, rad_pp_y_o}, {v, v ^ 16'h00ff});
    end
    for (int s = 0; s < 4; s++) begin
      @(posedge ref_clk_i);
      {delay_sel_i, mult_en_i, rad_pp_x_i, rad_pp_y_i} <= {2'(s), 1'b0, rad_danger_sp_i, 16'h0};
      tick(dly(2'(s)) + 5);
      chk(rad_danger_o, 0);
      @(posedge ref_clk_i);
      rad_pp_y_i <= rad_danger_sp_i;
      meas(n);
      chk(n, dly(2'(s)));
      @(posedge ref_clk_i);
      rad_pp_y_i <= 16'h0;
      tick(2);
      chk(rad_danger_o, 0);
    end
    @(posedge ref_clk_i);
    {rad_vote_single_i, delay_sel_i} <= 3'b100;
    meas(n);
    chk(n, SC);
    @(posedge ref_clk_i);
    {rad_vote_single_i, rad_gap_x_i, rad_pp_y_i} <= {1'b0, RAD_FLOOR_UM, rad_danger_sp_i};
    tick(SC + 5);
    chk({rad_danger_o, fault_o}, 6'h01);
    @(posedge ref_clk_i);
    {rad_gap_x_i, rad_pp_x_i, rad_pp_y_i} <= {16'h07d0, 16'h00c8, 16'h0};
    {rad_vote_single_i, mult_en_i, mult_contact_i} <= 3'b111;
    tick(SC + 5);
    chk({mult_active_o, rad_danger_o, rad_alert_o, rad_over_o, rad_pp_x_o}, 20'h900c8);
    @(posedge ref_clk_i);
    {mult_two_i, rad_range_wide_i} <= 2'b11;
    tick(SC + 5);
    chk({mult_active_o, rad_danger_o, rad_alert_o, rad_over_o}, 4'b1110);
    @(posedge ref_clk_i);
    {mult_en_i, mult_contact_i, rad_vote_single_i, rad_pp_x_i} <= '0;
    for (int c = 0; c < 6; c++) begin
      @(posedge ref_clk_i);
      {ax_vote_single_i, ax_gap_a_i, ax_gap_b_i} <= {ax_tab[c][5], ax_tab[c][4] ? 16'h64 : 16'h7d0,
                                                     ax_tab[c][3] ? 16'h64 : 16'h7d0};
      {ax_raw_a_i, ax_raw_b_i} <= {ax_tab[c][2] ? 16'sh258 : 16'sh0, ax_tab[c][1] ? 16'sh258 : 16'sh0};
      tick(SC + 5);
      chk({ax_danger_o, ax_alert_o}, {ax_tab[c][0], 1'b1});
    end
    @(posedge ref_clk_i);
    {ax_vote_single_i, ax_dir_down_i, ax_gap_a_i, ax_gap_b_i} <= {3'b011, 32'h07d007d0};
    {ax_raw_a_i, ax_raw_b_i} <= {16'sh0bb8, 16'sh012c};
    tick(2);
    chk({ax_pos_a_o, ax_pos_b_o}, 32'hfc18fe70);
    @(posedge ref_clk_i);
    mv <= 16'h1ebe;
    tick(6);
    chk(fault_o[4], 1);
    @(posedge ref_clk_i);
    mv <= 16'h3e80;
    repeat (300) @(posedge ref_clk_i);
    rod_base_rst_i <= 1'b1;
    repeat (5) @(posedge ref_clk_i);
    rod_base_rst_i <= 1'b0;
    tick(10);
    chk(rod_drop_o, 0);
    @(posedge ref_clk_i);
    mv <= 16'h4e20;
    tick(300);
    chk({rod_drop_o, rod_danger_o, rod_alert_o}, 18'h007f7);
    @(posedge ref_clk_i);
    rod_avg_mode_i <= 1'b1;
    tick(300);
    chk(rod_drop_o, 16'h01fd);
    @(posedge ref_clk_i);
    {rod_trim_i, rod_sf_low_i} <= {TRIM_MIN, 1'b1};
    tick(300);
    chk(rod_drop_o, 16'h01fa);
    complete_run();
  end
endmodule : test_smv_vote_top
